// ===== include/pld_defs.vh
// Constants for the loopback and diagnostics register bank
`ifndef PLD_DEFS_VH
`define PLD_DEFS_VH
`define PLD_ADDR_LOOPBACK 5'h13
`define PLD_ADDR_RXERR 5'h14
`define PLD_ADDR_ENERGY 5'h15
`define PLD_ADDR_IRQ_STAT 5'h1C
`define PLD_ADDR_IRQ_MASK 5'h1D
`define PLD_LB_IFACE 15
`define PLD_LB_ALLDIG 12
`define PLD_LB_LINEDRV 10
`define PLD_LB_REMOTE 9
`define PLD_LB_EXTCAB 7
`define PLD_LB_TXSUP 6
`define PLD_LB_FORCE 0
`define PLD_LB_RW_MASK 16'h96C1
`define PLD_LB_RESET 16'h1041
`define PLD_ED_PD 3
`define PLD_ED_PULSE 2
`define PLD_ED_RW_MASK 16'h000C
`define PLD_ED_RESET 16'h000C
`define PLD_IRQ_SAT 0
`define PLD_IRQ_LINK 1
`define PLD_IRQ_READY 2
`define PLD_IRQ_MASK_BITS 16'h0007
`define PLD_READY_MS 2
`define PLD_CLK_KHZ 200000
`define PLD_READY_CYCLES (`PLD_READY_MS * `PLD_CLK_KHZ)
`endif

// ===== core/pld_regs.v
// Loopback, receive error counter and energy-detect register bank
`timescale 1ns/100ps
`include "pld_defs.vh"
module pld_regs #(
  parameter [31:0] READY_CYCLES = `PLD_READY_CYCLES
) (
  // Clock and reset
  input wire CLK,
  input wire SYS_RST,
  // Register port
  input wire [4:0] ADDR,
  input wire [15:0] WDATA,
  input wire WR_STB,
  input wire RD_STB,
  output reg [15:0] RDATA,
  // Line status, main loopback, error events and count selects
  input wire MAIN_LOOPBACK,
  input wire LINK_UP,
  input wire CRC_ERR,
  input wire SYMBOL_ERR,
  input wire FALSE_CARRIER,
  input wire COUNT_SYMBOL,
  input wire COUNT_FALSE_CARRIER,
  // Loopback and power controls, link and ready status
  output reg IFACE_LOOPBACK,
  output reg ALLDIG_LOOPBACK,
  output reg LINEDRV_LOOPBACK,
  output reg REMOTE_LOOPBACK,
  output reg EXTCAB_LOOPBACK,
  output reg TX_SUPPRESS,
  output reg LINK_STATUS,
  output reg READY_FOR_DATA,
  output reg ENERGY_PD_EN,
  output reg NORMAL_LINK_PULSE_EN,
  // Interrupt
  output reg IRQ
);
  reg [15:0] loopback_control_ff;
  reg [15:0] energy_detect_control_ff;
  reg [15:0] rx_error_count_ff;
  reg [15:0] irq_stat_ff;
  reg [15:0] irq_mask_ff;
  reg [31:0] ready_cnt_ff;
  reg link_prev_ff;
  reg ready_prev_ff;
  reg [15:0] nxt_rx_error_count;
  reg [15:0] nxt_irq_stat;
  reg [15:0] nxt_rdata;
  reg [31:0] nxt_ready_cnt;
  reg nxt_link;
  reg nxt_ready;
  reg [1:0] err_inc;
  reg cnt_sat;

  // Register write with reserved bits kept at zero
  function [15:0] wr_field;
    input [15:0] data;
    input [15:0] mask;
    begin
      wr_field = data & mask;
    end
  endfunction

  // Strobe qualified by one register address
  function addr_hit;
    input stb;
    input [4:0] addr;
    input [4:0] target;
    begin
      addr_hit = stb && (addr == target);
    end
  endfunction

  wire rd_cnt = addr_hit(RD_STB, ADDR, `PLD_ADDR_RXERR);
  wire rd_stat = addr_hit(RD_STB, ADDR, `PLD_ADDR_IRQ_STAT);
  wire wr_lb = addr_hit(WR_STB, ADDR, `PLD_ADDR_LOOPBACK);
  wire wr_ed = addr_hit(WR_STB, ADDR, `PLD_ADDR_ENERGY);
  wire wr_mask = addr_hit(WR_STB, ADDR, `PLD_ADDR_IRQ_MASK);
  wire iface_on = loopback_control_ff[`PLD_LB_IFACE];
  wire any_other = loopback_control_ff[`PLD_LB_ALLDIG] |
    loopback_control_ff[`PLD_LB_LINEDRV] |
    loopback_control_ff[`PLD_LB_EXTCAB] |
    loopback_control_ff[`PLD_LB_REMOTE];

  // Error counter, link and readiness next values
  always @* begin
    err_inc = 2'b00;
    if (COUNT_SYMBOL) begin
      err_inc = {1'b0, SYMBOL_ERR};
    end else begin
      err_inc = {1'b0, CRC_ERR};
    end
    if (COUNT_FALSE_CARRIER && FALSE_CARRIER) begin
      err_inc = err_inc + 2'b01;
    end
    cnt_sat = 1'b0;
    if (rd_cnt) begin
      nxt_rx_error_count = {14'h0000, err_inc};
    end else if ({1'b0, rx_error_count_ff} + {15'h0000, err_inc} > 17'h0FFFF) begin
      nxt_rx_error_count = 16'hFFFF;
      cnt_sat = 1'b1;
    end else begin
      nxt_rx_error_count = rx_error_count_ff + {14'h0000, err_inc};
    end
    if (iface_on) begin
      nxt_link = loopback_control_ff[`PLD_LB_FORCE];
    end else begin
      nxt_link = LINK_UP;
    end
    nxt_ready_cnt = ready_cnt_ff;
    if (iface_on && MAIN_LOOPBACK) begin
      if (ready_cnt_ff < READY_CYCLES) begin
        nxt_ready_cnt = ready_cnt_ff + 32'h00000001;
      end
    end else begin
      nxt_ready_cnt = 32'h00000000;
    end
    if (iface_on) begin
      nxt_ready = (ready_cnt_ff >= READY_CYCLES);
    end else if (loopback_control_ff[`PLD_LB_REMOTE]) begin
      nxt_ready = 1'b0;
    end else if (any_other) begin
      nxt_ready = nxt_link;
    end else begin
      nxt_ready = LINK_UP;
    end
    nxt_irq_stat = rd_stat ? 16'h0000 : irq_stat_ff;
    if (cnt_sat) begin
      nxt_irq_stat[`PLD_IRQ_SAT] = 1'b1;
    end
    if (nxt_link != link_prev_ff) begin
      nxt_irq_stat[`PLD_IRQ_LINK] = 1'b1;
    end
    if (nxt_ready && !ready_prev_ff) begin
      nxt_irq_stat[`PLD_IRQ_READY] = 1'b1;
    end
  end

  // Read data mux, unmapped addresses read zero
  always @* begin
    case (ADDR)
      `PLD_ADDR_LOOPBACK: nxt_rdata = loopback_control_ff;
      `PLD_ADDR_RXERR: nxt_rdata = rx_error_count_ff;
      `PLD_ADDR_ENERGY: nxt_rdata = energy_detect_control_ff;
      `PLD_ADDR_IRQ_STAT: nxt_rdata = irq_stat_ff;
      `PLD_ADDR_IRQ_MASK: nxt_rdata = irq_mask_ff;
      default: nxt_rdata = 16'h0000;
    endcase
  end

  // Loopback control register
  always @(posedge CLK) begin
    if (SYS_RST) begin
      loopback_control_ff <= `PLD_LB_RESET;
    end else if (wr_lb) begin
      loopback_control_ff <= wr_field(WDATA, `PLD_LB_RW_MASK);
    end
  end

  // Energy-detect control register
  always @(posedge CLK) begin
    if (SYS_RST) begin
      energy_detect_control_ff <= `PLD_ED_RESET;
    end else if (wr_ed) begin
      energy_detect_control_ff <= wr_field(WDATA, `PLD_ED_RW_MASK);
    end
  end

  // Interrupt mask register
  always @(posedge CLK) begin
    if (SYS_RST) begin
      irq_mask_ff <= 16'h0000;
    end else if (wr_mask) begin
      irq_mask_ff <= wr_field(WDATA, `PLD_IRQ_MASK_BITS);
    end
  end

  // Receive error counter
  always @(posedge CLK) begin
    if (SYS_RST) begin
      rx_error_count_ff <= 16'h0000;
    end else begin
      rx_error_count_ff <= nxt_rx_error_count;
    end
  end

  // Sticky interrupt status
  always @(posedge CLK) begin
    if (SYS_RST) begin
      irq_stat_ff <= 16'h0000;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
    end
  end

  // Interface-mode readiness timer
  always @(posedge CLK) begin
    if (SYS_RST) begin
      ready_cnt_ff <= 32'h00000000;
    end else begin
      ready_cnt_ff <= nxt_ready_cnt;
    end
  end

  // History for status edge detection
  always @(posedge CLK) begin
    if (SYS_RST) begin
      link_prev_ff <= 1'b0;
      ready_prev_ff <= 1'b0;
    end else begin
      link_prev_ff <= nxt_link;
      ready_prev_ff <= nxt_ready;
    end
  end

  // Read data, zero outside the answer cycle
  always @(posedge CLK) begin
    if (SYS_RST) begin
      RDATA <= 16'h0000;
    end else begin
      RDATA <= RD_STB ? nxt_rdata : 16'h0000;
    end
  end

  // Interface loopback output
  always @(posedge CLK) begin
    if (SYS_RST) begin
      IFACE_LOOPBACK <= 1'b0;
    end else begin
      IFACE_LOOPBACK <= loopback_control_ff[`PLD_LB_IFACE];
    end
  end

  // All-digital loopback output
  always @(posedge CLK) begin
    if (SYS_RST) begin
      ALLDIG_LOOPBACK <= 1'b0;
    end else begin
      ALLDIG_LOOPBACK <= loopback_control_ff[`PLD_LB_ALLDIG];
    end
  end

  // Line-driver loopback output
  always @(posedge CLK) begin
    if (SYS_RST) begin
      LINEDRV_LOOPBACK <= 1'b0;
    end else begin
      LINEDRV_LOOPBACK <= loopback_control_ff[`PLD_LB_LINEDRV];
    end
  end

  // Remote loopback output
  always @(posedge CLK) begin
    if (SYS_RST) begin
      REMOTE_LOOPBACK <= 1'b0;
    end else begin
      REMOTE_LOOPBACK <= loopback_control_ff[`PLD_LB_REMOTE];
    end
  end

  // External-cable loopback output
  always @(posedge CLK) begin
    if (SYS_RST) begin
      EXTCAB_LOOPBACK <= 1'b0;
    end else begin
      EXTCAB_LOOPBACK <= loopback_control_ff[`PLD_LB_EXTCAB];
    end
  end

  // Transmit suppression only while all-digital loopback is on
  always @(posedge CLK) begin
    if (SYS_RST) begin
      TX_SUPPRESS <= 1'b0;
    end else begin
      TX_SUPPRESS <= loopback_control_ff[`PLD_LB_ALLDIG] &
        loopback_control_ff[`PLD_LB_TXSUP];
    end
  end

  // Link status indication
  always @(posedge CLK) begin
    if (SYS_RST) begin
      LINK_STATUS <= 1'b0;
    end else begin
      LINK_STATUS <= nxt_link;
    end
  end

  // Ready for data indication
  always @(posedge CLK) begin
    if (SYS_RST) begin
      READY_FOR_DATA <= 1'b0;
    end else begin
      READY_FOR_DATA <= nxt_ready;
    end
  end

  // Energy-detect power-down enable
  always @(posedge CLK) begin
    if (SYS_RST) begin
      ENERGY_PD_EN <= 1'b0;
    end else begin
      ENERGY_PD_EN <= energy_detect_control_ff[`PLD_ED_PD];
    end
  end

  // Link pulses only inside energy-detect power-down
  always @(posedge CLK) begin
    if (SYS_RST) begin
      NORMAL_LINK_PULSE_EN <= 1'b0;
    end else begin
      NORMAL_LINK_PULSE_EN <= energy_detect_control_ff[`PLD_ED_PD] &
        energy_detect_control_ff[`PLD_ED_PULSE];
    end
  end

  // Level interrupt from unmasked status
  always @(posedge CLK) begin
    if (SYS_RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(nxt_irq_stat & irq_mask_ff);
    end
  end
endmodule

// ===== tb/pld_host.sv
// Management host model that sets the main loopback bit
`timescale 1ns/100ps
module pld_host (
  // Mode outputs of the bank
  input wire iface,
  input wire alldig,
  input wire linedrv,
  // Main control loopback bit
  output wire main_lb
);
  assign main_lb = iface | alldig | linedrv;
endmodule

// ===== tb/pld_chk.sv
// Assertion checker for the loopback and diagnostics bank
`timescale 1ns/100ps
module pld_chk (
  // Clock, reset and register port
  input wire CLK, input wire SYS_RST, input wire WR_STB, input wire RD_STB,
  input wire [4:0] ADDR, input wire [15:0] RDATA,
  // Line events and controls
  input wire LINK_UP, input wire CRC_ERR, input wire SYMBOL_ERR, input wire FALSE_CARRIER,
  input wire IFACE_LOOPBACK, input wire ALLDIG_LOOPBACK, input wire REMOTE_LOOPBACK,
  input wire TX_SUPPRESS, input wire LINK_STATUS, input wire READY_FOR_DATA,
  input wire ENERGY_PD_EN, input wire NORMAL_LINK_PULSE_EN
);
  reg [2:0] age_ff;
  always @(posedge CLK) age_ff <= SYS_RST ? 3'h0 : age_ff + {2'h0, age_ff != 3'h7};
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  sequence cnt_rd; RD_STB && ADDR == 5'h14; endsequence
  sequence cnt_rd_quiet; cnt_rd ##0 !(CRC_ERR | SYMBOL_ERR | FALSE_CARRIER); endsequence
  chk_tx_suppress: assert property (TX_SUPPRESS |-> ALLDIG_LOOPBACK)
    else $error("tx suppress bad");
  chk_pulse_needs_pd: assert property (NORMAL_LINK_PULSE_EN |-> ENERGY_PD_EN)
    else $error("link pulse bad");
  chk_link_follow: assert property (age_ff > 3'h3 && !IFACE_LOOPBACK |->
    LINK_STATUS == $past(LINK_UP)) else $error("link status bad");
  chk_remote_never: assert property (REMOTE_LOOPBACK && $past(REMOTE_LOOPBACK) &&
    !IFACE_LOOPBACK |-> !READY_FOR_DATA) else $error("remote ready");
  chk_read_idle: assert property (!$past(RD_STB) ||
    !($past(ADDR) inside {5'h13, 5'h14, 5'h15, 5'h1C, 5'h1D}) |-> RDATA == 16'h0000)
    else $error("read data not zero");
  chk_lb_reserved: assert property ($past(RD_STB) && $past(ADDR) == 5'h13 |->
    (RDATA & 16'h693E) == 16'h0000) else $error("reserved bits set");
  chk_read_clear: assert property (cnt_rd_quiet ##1 cnt_rd |=> RDATA == 16'h0000)
    else $error("counter not cleared");
  chk_pd_stable: assert property (age_ff > 3'h3 && $changed(ENERGY_PD_EN) |->
    $past(WR_STB, 2) && $past(ADDR, 2) == 5'h15) else $error("power-down changed");
endmodule
bind pld_regs pld_chk u_pld_chk (.*);

// ===== tb/tb.sv
// Self-checking bench for the loopback and diagnostics bank
`timescale 1ns/100ps
`define CK(a, x) begin num_checks++; if ((a) !== (x)) begin fail_count++; \
  $display("Error t=%0t got %h exp %h", $time, a, x); end end
module tb;
  reg CLK = 0, SYS_RST = 1, WR_STB = 0, RD_STB = 0, LINK_UP = 0, rd_d = 0;
  reg CRC_ERR = 0, SYMBOL_ERR = 0, FALSE_CARRIER = 0, COUNT_SYMBOL = 0, COUNT_FALSE_CARRIER = 0;
  reg [4:0] ADDR = 0;
  reg [15:0] WDATA = 0, w;
  wire [15:0] RDATA;
  wire MAIN_LOOPBACK, IFACE_LOOPBACK, ALLDIG_LOOPBACK, LINEDRV_LOOPBACK, REMOTE_LOOPBACK;
  wire EXTCAB_LOOPBACK, TX_SUPPRESS, LINK_STATUS, READY_FOR_DATA, ENERGY_PD_EN;
  wire NORMAL_LINK_PULSE_EN, IRQ;
  logic [16:0] exp_q[$], e;
  integer seed = 73338, fail_count = 0, num_checks = 0, i, n;
  int bits[5] = '{15, 12, 10, 9, 7};
  always #2.5 CLK = ~CLK;
  pld_regs #(.READY_CYCLES(32'd20)) u_pld_regs (.*);
  pld_host u_pld_host (.iface(IFACE_LOOPBACK), .alldig(ALLDIG_LOOPBACK),
    .linedrv(LINEDRV_LOOPBACK), .main_lb(MAIN_LOOPBACK));
  task bus(input wr, input rd, input [4:0] a, input [15:0] d);
    WR_STB <= wr;
    RD_STB <= rd;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK);
  endtask
  task idle(input integer k); repeat (k) bus(0, 0, 5'h00, 16'h0000); endtask
  task rd(input [4:0] a, input [16:0] x);
    exp_q.push_back(x);
    bus(0, 1, a, $random(seed));
  endtask
  task errs;
    for (n = 0; n < 3; n++) begin
      {FALSE_CARRIER, SYMBOL_ERR, CRC_ERR} <= 3'h1 << n;
      idle(1);
    end
    {FALSE_CARRIER, SYMBOL_ERR, CRC_ERR} <= 3'h0;
  endtask
  task summarize;
    if (fail_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge CLK) rd_d <= RD_STB;
  always @(negedge CLK) if (rd_d) begin
    e = exp_q.pop_front();
    if (!e[16]) `CK(RDATA, e[15:0])
  end
  initial begin
    repeat (6) @(posedge CLK);
    SYS_RST <= 0;
    idle(3);
    #1 `CK({ALLDIG_LOOPBACK, TX_SUPPRESS, ENERGY_PD_EN, NORMAL_LINK_PULSE_EN}, 4'hF)
    rd(5'h13, 17'h01041);
    rd(5'h15, 17'h0000C);
    bus(1, 0, 5'h14, 16'hFFFF);
    rd(5'h14, 17'h0);
    rd(5'h00, 17'h0);
    LINK_UP <= 1;
    for (i = 0; i < 5; i++) begin
      w = 16'h0041 | (16'h1 << bits[i]) | ($random(seed) & 16'h693E);
      bus(1, 0, 5'h13, w);
      rd(5'h13, {1'b0, w & 16'h96C1});
      idle(2);
      #1 `CK({IFACE_LOOPBACK, ALLDIG_LOOPBACK, LINEDRV_LOOPBACK, REMOTE_LOOPBACK,
        EXTCAB_LOOPBACK}, 5'h10 >> i)
      `CK(TX_SUPPRESS, i == 1)
      `CK(LINK_STATUS, 1'b1)
      if (i > 0) `CK(READY_FOR_DATA, i != 3)
    end
    LINK_UP <= 0;
    bus(1, 0, 5'h13, 16'h0000);
    idle(3);
    bus(1, 0, 5'h13, 16'h8001);
    for (n = 0; n < 60 && READY_FOR_DATA !== 1'b1; n++) begin
      idle(1);
      #1;
    end
    `CK(n > 15 && n < 60, 1'b1)
    if (n == 60) summarize;
    `CK(LINK_STATUS, 1'b1)
    LINK_UP <= 1;
    bus(1, 0, 5'h13, 16'h8000);
    idle(2);
    #1 `CK(LINK_STATUS, 1'b0)
    for (i = 0; i < 4; i++) begin
      {COUNT_FALSE_CARRIER, COUNT_SYMBOL} <= i[1:0];
      errs;
      rd(5'h14, 17'd1 + i[1]);
      rd(5'h14, 17'h0);
    end
    for (i = 0; i < 4; i++) begin
      w = $random(seed);
      w[3:2] = i[1:0];
      bus(1, 0, 5'h15, w);
      rd(5'h15, {13'h0, w[3:2], 2'h0});
      idle(1);
      #1 `CK({ENERGY_PD_EN, NORMAL_LINK_PULSE_EN}, {w[3], w[3] & w[2]})
    end
    bus(1, 0, 5'h1D, 16'hFFFF);
    rd(5'h1D, 17'h00007);
    idle(1);
    #1 `CK(IRQ, 1'b1)
    rd(5'h1C, 17'h00006);
    bus(1, 0, 5'h1D, 16'h0000);
    bus(1, 0, 5'h13, 16'h0000);
    idle(3);
    #1 `CK(IRQ, 1'b0)
    bus(1, 0, 5'h1D, 16'h0002);
    idle(2);
    #1 `CK(IRQ, 1'b1)
    rd(5'h1C, 17'h00002);
    idle(2);
    summarize;
  end
endmodule
